/* ccs_host.sv */
`timescale 1ns/1ns
// ==========================================
// Host socket model: byte cycles to attribute memory
module ccs_host
  import ccs_pkg::*;
(
  // Clock
  input wire logic clock,
  // Socket strobes and bus
  output logic reg_n,
  output logic ce1_n,
  output logic oe_n,
  output logic we_n,
  output logic [10:0] addr,
  output logic [7:0] data_in,
  // Card answer
  input wire logic [7:0] data_out,
  input wire logic data_oe
);
  // Extra cycles of strobe hold, set by the bench for slow hosts
  int slow = 0;

  initial begin
    reg_n = 1'b1;
    ce1_n = 1'b1;
    oe_n = 1'b1;
    we_n = 1'b1;
    addr = 11'h000;
    data_in = 8'h00;
  end

  // Released lines show inverted values so stale data cannot pass as held
  task automatic park(input logic [10:0] a, input logic [7:0] d);
    reg_n <= 1'b1;
    ce1_n <= 1'b1;
    oe_n <= 1'b1;
    we_n <= 1'b1;
    addr <= ~a;
    data_in <= ~d;
    repeat (5) @(posedge clock);
  endtask

  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_n <= 1'b0;
    ce1_n <= 1'b0;
    addr <= a;
    data_in <= d;
    we_n <= 1'b0;
    repeat (5 + slow) @(posedge clock);
    we_n <= 1'b1;
    // The card takes the byte late, so address and data outlive the strobe
    repeat (5) @(posedge clock);
    park(a, d);
  endtask

  task automatic rd(input logic [10:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge clock);
    reg_n <= 1'b0;
    ce1_n <= 1'b0;
    addr <= a;
    oe_n <= 1'b0;
    for (int n = 0; n < 8 + slow && !ok; n++) begin
      @(negedge clock);
      if (data_oe === 1'b1 && n >= 3 + slow) begin
        ok = 1'b1;
        d = data_out;
      end
    end
    @(posedge clock);
    park(a, 8'h00);
  endtask
endmodule

/* ccs_pkg.sv */
package ccs_pkg;
  // ==========================================
  // Attribute memory map
  localparam logic [10:0] CCS_BASE = 11'h200;
  localparam logic [8:0] CCS_OFS_OPTION = 9'h000;
  localparam logic [8:0] CCS_OFS_STATUS = 9'h002;
  localparam logic [8:0] CCS_OFS_PINREP = 9'h004;

  // ==========================================
  // Option register fields
  localparam int CCS_OPT_SOFT_RESET = 7;
  localparam int CCS_OPT_LEVIRQ = 6;
  localparam logic [5:0] CCS_IDX_MEMORY = 6'h00;
  localparam logic [5:0] CCS_IDX_IO_ANY16 = 6'h01;
  localparam logic [5:0] CCS_IDX_IO_PRIMARY = 6'h02;
  localparam logic [5:0] CCS_IDX_IO_SECONDARY = 6'h03;

  // ==========================================
  // Status register fields
  localparam int CCS_STS_CHANGED = 7;
  localparam int CCS_STS_CHG_ENABLE = 6;
  localparam int CCS_STS_IO8 = 5;
  localparam int CCS_STS_PL1DIS = 4;
  localparam int CCS_STS_AUDIO = 3;
  localparam int CCS_STS_PWRDN = 2;
  localparam int CCS_STS_INT = 1;

  // ==========================================
  // Pin replacement fields
  localparam int CCS_PR_READY_CHG = 5;
  localparam int CCS_PR_WP_CHG = 4;
  localparam int CCS_PR_RREADY = 1;
  localparam int CCS_PR_WP_MASK = 0;
  localparam logic [7:0] CCS_PR_FIXED_ONES = 8'h0c;

  // ==========================================
  // Reset values
  localparam logic [7:0] CCS_OPTION_RESET = 8'h00;
  localparam logic [7:0] CCS_STATUS_RESET = 8'h00;
  localparam logic [22:0] CCS_PINS_IDLE = 23'h7fffff;

  typedef enum logic [1:0] {
    CCS_PWR_ACTIVE = 2'b00,
    CCS_PWR_ENTER = 2'b01,
    CCS_PWR_DOWN = 2'b10,
    CCS_PWR_LEAVE = 2'b11
  } ccs_pwr_e;
endpackage

/* ccs_regs.sv */
`timescale 1ns/1ns
module ccs_regs
  import ccs_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Host socket pins
  input wire logic reg_n,
  input wire logic ce1_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [10:0] addr,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic state_change_pin_n,
  output logic ready_pin,
  output logic speaker_out,
  // Card core side
  input wire logic card_ready,
  input wire logic write_protect_state,
  input wire logic irq_request,
  input wire logic host_irq_disable,
  input wire logic idle_timeout,
  input wire logic command_received,
  input wire logic audio_in,
  input wire logic power_is_down,
  output logic core_hard_reset,
  output logic level_irq_select,
  output logic mode_memory,
  output logic mode_io_any16,
  output logic mode_io_primary,
  output logic mode_io_secondary,
  output logic power_down,
  output logic power_level1_disable
);

  // ==========================================
  // Pin synchronisers
  logic [22:0] pin_meta;
  logic [22:0] pin_sync;
  logic [22:0] pin_last;
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_meta <= CCS_PINS_IDLE;
      pin_sync <= CCS_PINS_IDLE;
      pin_last <= CCS_PINS_IDLE;
    end else begin
      pin_meta <= {reg_n, ce1_n, oe_n, we_n, addr, data_in};
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  // ==========================================
  // Attribute cycle decode
  wire logic s_reg_n = pin_sync[22];
  wire logic s_ce1_n = pin_sync[21];
  wire logic s_oe_n = pin_sync[20];
  wire logic [10:0] s_addr = pin_sync[18:8];
  wire logic l_reg_n = pin_last[22];
  wire logic l_ce1_n = pin_last[21];
  wire logic l_we_n = pin_last[19];
  wire logic [10:0] l_addr = pin_last[18:8];
  wire logic [7:0] l_data = pin_last[7:0];
  wire logic s_we_n = pin_sync[19];
  // Odd addresses never match since every offset is even
  wire logic [10:0] s_rel = s_addr - CCS_BASE;
  wire logic [10:0] l_rel = l_addr - CCS_BASE;
  wire logic s_attr = !s_reg_n && !s_ce1_n && s_addr[10:9] == CCS_BASE[10:9];
  wire logic l_attr = !l_reg_n && !l_ce1_n && l_addr[10:9] == CCS_BASE[10:9];
  wire logic rd_sel = s_attr && !s_oe_n && s_we_n;
  // A write is taken at the release of the write strobe, when data has settled
  wire logic wr_fire = l_attr && !l_we_n && s_we_n;
  wire logic wr_option = wr_fire && l_rel[8:0] == CCS_OFS_OPTION;
  wire logic wr_status = wr_fire && l_rel[8:0] == CCS_OFS_STATUS;
  wire logic wr_pinrep = wr_fire && l_rel[8:0] == CCS_OFS_PINREP;

  // ==========================================
  // Soft reset
  logic soft_reset_bit;
  always_ff @(posedge clock) begin
    if (rst) begin
      soft_reset_bit <= 1'b0;
    end else if (wr_option) begin
      soft_reset_bit <= l_data[CCS_OPT_SOFT_RESET];
    end
  end
  // Everything but the soft reset bit, the pin synchronisers and the read path restarts from this
  wire logic card_reset = rst || soft_reset_bit;

  always_ff @(posedge clock) begin
    if (rst) begin
      core_hard_reset <= 1'b1;
    end else begin
      core_hard_reset <= card_reset;
    end
  end

  // ==========================================
  // Option register
  logic [5:0] config_index;
  always_ff @(posedge clock) begin
    if (card_reset) begin
      level_irq_select <= 1'b0;
      config_index <= CCS_OPTION_RESET[5:0];
    end else if (wr_option) begin
      level_irq_select <= l_data[CCS_OPT_LEVIRQ];
      config_index <= l_data[5:0];
    end
  end

  // Any reserved upper index bit set leaves the card in no mode at all
  wire logic idx_upper_clear = config_index[5:4] == 2'b00;
  wire logic dec_memory = config_index == CCS_IDX_MEMORY;
  wire logic dec_any16 = idx_upper_clear && config_index[3:0] == CCS_IDX_IO_ANY16[3:0];
  wire logic dec_primary = idx_upper_clear && config_index[3:0] == CCS_IDX_IO_PRIMARY[3:0];
  wire logic dec_secondary = idx_upper_clear && config_index[3:0] == CCS_IDX_IO_SECONDARY[3:0];
  wire logic io_mode = dec_any16 || dec_primary || dec_secondary;

  always_ff @(posedge clock) begin
    if (card_reset) begin
      mode_memory <= 1'b1;
      mode_io_any16 <= 1'b0;
      mode_io_primary <= 1'b0;
      mode_io_secondary <= 1'b0;
    end else begin
      mode_memory <= dec_memory;
      mode_io_any16 <= dec_any16;
      mode_io_primary <= dec_primary;
      mode_io_secondary <= dec_secondary;
    end
  end

  // ==========================================
  // Status register
  logic state_change_enable;
  logic byte_io_request;
  logic audio_enable;
  logic power_down_request;
  always_ff @(posedge clock) begin
    if (card_reset) begin
      state_change_enable <= CCS_STATUS_RESET[CCS_STS_CHG_ENABLE];
      byte_io_request <= CCS_STATUS_RESET[CCS_STS_IO8];
      power_level1_disable <= CCS_STATUS_RESET[CCS_STS_PL1DIS];
      audio_enable <= CCS_STATUS_RESET[CCS_STS_AUDIO];
      power_down_request <= CCS_STATUS_RESET[CCS_STS_PWRDN];
    end else if (wr_status) begin
      state_change_enable <= l_data[CCS_STS_CHG_ENABLE];
      // Stored for read-back only; both I/O widths stay accepted
      byte_io_request <= l_data[CCS_STS_IO8];
      power_level1_disable <= l_data[CCS_STS_PL1DIS];
      audio_enable <= l_data[CCS_STS_AUDIO];
      power_down_request <= l_data[CCS_STS_PWRDN];
    end
  end

  wire logic irq_visible = irq_request && !host_irq_disable;
  always_ff @(posedge clock) begin
    if (card_reset) begin
      speaker_out <= 1'b0;
    end else begin
      speaker_out <= audio_enable && audio_in && !mode_memory;
    end
  end

  // ==========================================
  // Pin replacement register
  logic ready_changed;
  logic write_protect_changed;
  logic ready_seen;
  logic wp_seen;
  wire logic ready_event = card_ready != ready_seen;
  wire logic wp_event = write_protect_state != wp_seen;
  wire logic ready_mask = wr_pinrep && l_data[CCS_PR_RREADY];
  wire logic wp_mask = wr_pinrep && l_data[CCS_PR_WP_MASK];
  // A hardware change in the same cycle as a host clear still sets the bit
  wire logic next_ready_changed = ready_event || (ready_mask ? l_data[CCS_PR_READY_CHG] : ready_changed);
  wire logic next_wp_changed = wp_event || (wp_mask ? l_data[CCS_PR_WP_CHG] : write_protect_changed);

  always_ff @(posedge clock) begin
    if (card_reset) begin
      ready_seen <= card_ready;
      wp_seen <= write_protect_state;
      ready_changed <= 1'b0;
      write_protect_changed <= 1'b0;
    end else begin
      ready_seen <= card_ready;
      wp_seen <= write_protect_state;
      ready_changed <= next_ready_changed;
      write_protect_changed <= next_wp_changed;
    end
  end

  wire logic changed = ready_changed || write_protect_changed;

  always_ff @(posedge clock) begin
    if (card_reset) begin
      state_change_pin_n <= 1'b1;
    end else begin
      state_change_pin_n <= !(io_mode && state_change_enable && changed);
    end
  end

  // ==========================================
  // Power state and READY
  ccs_pwr_e pwr_state;
  ccs_pwr_e next_pwr_state;
  logic idle_down;
  always_ff @(posedge clock) begin
    if (card_reset) begin
      idle_down <= 1'b0;
    end else if (command_received) begin
      idle_down <= 1'b0;
    end else if (idle_timeout) begin
      idle_down <= 1'b1;
    end
  end
  wire logic want_down = power_down_request || idle_down;
  wire logic pd_changed = wr_status && l_data[CCS_STS_PWRDN] != power_down_request;

  always_comb begin
    next_pwr_state = pwr_state;
    case (pwr_state)
      CCS_PWR_ACTIVE: begin
        if (pd_changed || want_down) next_pwr_state = CCS_PWR_ENTER;
      end
      CCS_PWR_ENTER: begin
        if (!want_down) next_pwr_state = CCS_PWR_LEAVE;
        else if (power_is_down) next_pwr_state = CCS_PWR_DOWN;
      end
      CCS_PWR_DOWN: begin
        if (pd_changed || !want_down) next_pwr_state = CCS_PWR_LEAVE;
      end
      CCS_PWR_LEAVE: begin
        if (want_down) next_pwr_state = CCS_PWR_ENTER;
        else if (!power_is_down) next_pwr_state = CCS_PWR_ACTIVE;
      end
      default: next_pwr_state = CCS_PWR_ACTIVE;
    endcase
  end
  // Any toggle of the request drops READY at once, even if the core is already there
  wire logic pwr_busy = pd_changed || next_pwr_state == CCS_PWR_ENTER || next_pwr_state == CCS_PWR_LEAVE;

  always_ff @(posedge clock) begin
    if (card_reset) begin
      pwr_state <= CCS_PWR_ACTIVE;
      power_down <= 1'b0;
      ready_pin <= 1'b0;
    end else begin
      pwr_state <= next_pwr_state;
      power_down <= want_down;
      ready_pin <= card_ready && !pwr_busy;
    end
  end

  // ==========================================
  // Read path
  wire logic [7:0] rd_option = {soft_reset_bit, level_irq_select, config_index};
  wire logic [7:0] rd_status = {changed, state_change_enable, byte_io_request, power_level1_disable,
                                audio_enable, power_down_request, irq_visible, 1'b0};
  wire logic [7:0] rd_pinrep = CCS_PR_FIXED_ONES | {2'b00, ready_changed, write_protect_changed,
                                2'b00, card_ready, 1'b0};
  wire logic [7:0] rd_mux = (s_rel[8:0] == CCS_OFS_OPTION) ? rd_option :
                            (s_rel[8:0] == CCS_OFS_STATUS) ? rd_status :
                            (s_rel[8:0] == CCS_OFS_PINREP) ? rd_pinrep : 8'h00;
  wire logic rd_hit = rd_sel && (s_rel[8:0] == CCS_OFS_OPTION || s_rel[8:0] == CCS_OFS_STATUS ||
                                 s_rel[8:0] == CCS_OFS_PINREP);

  always_ff @(posedge clock) begin
    if (rst) begin
      data_out <= 8'h00;
      data_oe <= 1'b0;
    end else begin
      data_out <= rd_hit ? rd_mux : 8'h00;
      data_oe <= rd_hit;
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_soft_reset_hold;
    wr_option && l_data[CCS_OPT_SOFT_RESET] |=> soft_reset_bit ##1 (core_hard_reset && !level_irq_select);
  endproperty
  a_soft_reset_hold: assert property (p_soft_reset_hold) else $error("soft reset not applied");

  property p_reset_clears;
    $fell(rst) |-> !soft_reset_bit && config_index == 6'h00 && !power_level1_disable;
  endproperty
  a_reset_clears: assert property (@(posedge clock) p_reset_clears) else $error("reset value wrong");

  property p_index_write;
    wr_option && !soft_reset_bit && !l_data[CCS_OPT_SOFT_RESET] |=>
      config_index == $past(l_data[5:0]) ##1 mode_memory == (config_index == 6'h00);
  endproperty
  a_index_write: assert property (p_index_write) else $error("index or decode wrong");

  property p_changed_read;
    rd_hit && s_rel[8:0] == CCS_OFS_STATUS |=> data_oe && data_out[7] == $past(changed) && !data_out[0];
  endproperty
  a_changed_read: assert property (p_changed_read) else $error("status read wrong");

  property p_state_change_pin;
    !card_reset && io_mode && state_change_enable && changed |=> !state_change_pin_n;
  endproperty
  a_state_change_pin: assert property (p_state_change_pin) else $error("state change pin not low");

  property p_state_change_pin_off;
    !state_change_enable ##1 !card_reset |-> state_change_pin_n;
  endproperty
  a_state_change_pin_off: assert property (p_state_change_pin_off) else $error("state change pin low while disabled");

  property p_pd_busy;
    pd_changed |=> !ready_pin;
  endproperty
  a_pd_busy: assert property (p_pd_busy) else $error("ready not busy on power change");

  property p_irq_masked;
    rd_hit && s_rel[8:0] == CCS_OFS_STATUS && host_irq_disable |=> !data_out[1];
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("interrupt bit not masked");

  property p_ready_event;
    ready_event && !card_reset |=> ready_changed;
  endproperty
  a_ready_event: assert property (p_ready_event) else $error("ready change lost");

  property p_mask_hold;
    wr_pinrep && !l_data[CCS_PR_RREADY] && !ready_event && !card_reset |=> ready_changed == $past(ready_changed);
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("unmasked ready changed bit moved");

  property p_pinrep_fixed;
    rd_hit && s_rel[8:0] == CCS_OFS_PINREP |=> data_out[7:6] == 2'b00 && data_out[3:2] == 2'b11 && !data_out[0];
  endproperty
  a_pinrep_fixed: assert property (p_pinrep_fixed) else $error("pin replacement fixed bits wrong");

  c_soft_reset: cover property (wr_option && l_data[CCS_OPT_SOFT_RESET]);
  c_io_state_change_pin: cover property (!state_change_pin_n);
  c_power_down: cover property (pwr_state == CCS_PWR_DOWN);
  c_mask_clear: cover property (wr_pinrep && ready_mask && !l_data[CCS_PR_READY_CHG]);
endmodule

/* ccs_tb.sv */
`timescale 1ns/1ns
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH at %0t: got %h expected %h", $time, g, e); end end
module testbench
  import ccs_pkg::*;
;
  logic clock;
  logic rst;
  wire logic reg_n, ce1_n, oe_n, we_n;
  wire logic [10:0] addr;
  wire logic [7:0] data_in;
  logic [7:0] data_out;
  logic data_oe, state_change_pin_n, ready_pin, speaker_out;
  logic card_ready, write_protect_state, irq_request, host_irq_disable;
  logic idle_timeout, command_received, audio_in, power_is_down;
  logic core_hard_reset, level_irq_select, power_down, power_level1_disable;
  logic mode_memory, mode_io_any16, mode_io_primary, mode_io_secondary;
  int n_fail = 0;
  int comparisons = 0;

  ccs_regs dut (.clock(clock), .rst(rst), .reg_n(reg_n), .ce1_n(ce1_n), .oe_n(oe_n),
    .we_n(we_n), .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .state_change_pin_n(state_change_pin_n), .ready_pin(ready_pin), .speaker_out(speaker_out),
    .card_ready(card_ready), .write_protect_state(write_protect_state),
    .irq_request(irq_request), .host_irq_disable(host_irq_disable),
    .idle_timeout(idle_timeout), .command_received(command_received), .audio_in(audio_in),
    .power_is_down(power_is_down), .core_hard_reset(core_hard_reset),
    .level_irq_select(level_irq_select), .mode_memory(mode_memory),
    .mode_io_any16(mode_io_any16), .mode_io_primary(mode_io_primary),
    .mode_io_secondary(mode_io_secondary), .power_down(power_down),
    .power_level1_disable(power_level1_disable));

  ccs_host host (.clock(clock), .reg_n(reg_n), .ce1_n(ce1_n), .oe_n(oe_n), .we_n(we_n),
    .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe));

  initial clock = 1'b0;
  always #5 clock = ~clock;

  // ==========================================
  // Access helpers
  task automatic wreg(input logic [8:0] ofs, input logic [7:0] d);
    host.wr(CCS_BASE + 11'(ofs), d);
  endtask

  task automatic rchk(input logic [8:0] ofs, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    host.rd(CCS_BASE + 11'(ofs), d, ok);
    `CHK(ok, 1'b1)
    `CHK(d, e)
  endtask

  task automatic waitc(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic end_sim;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================
  // Tests
  initial begin
    logic [7:0] d;
    logic ok;
    rst = 1'b1;
    card_ready = 1'b1;
    write_protect_state = 1'b0;
    irq_request = 1'b0;
    host_irq_disable = 1'b0;
    idle_timeout = 1'b0;
    command_received = 1'b0;
    audio_in = 1'b1;
    power_is_down = 1'b0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    waitc(3);
    `CHK(core_hard_reset, 1'b0)
    `CHK(mode_memory, 1'b1)
    rchk(CCS_OFS_OPTION, 8'h00);
    rchk(CCS_OFS_STATUS, 8'h00);
    rchk(CCS_OFS_PINREP, 8'h0e);
    host.slow = 2;
    for (int i = 0; i < 4; i++) begin
      wreg(CCS_OFS_OPTION, {1'b0, i[0], 6'(i)});
      `CHK({mode_memory, mode_io_any16, mode_io_primary, mode_io_secondary}, 4'h8 >> i)
      `CHK(level_irq_select, i[0])
      rchk(CCS_OFS_OPTION, {1'b0, i[0], 6'(i)});
    end
    host.slow = 0;
    wreg(CCS_OFS_STATUS, 8'h70);
    rchk(CCS_OFS_STATUS, 8'h70);
    `CHK(power_level1_disable, 1'b1)
    `CHK(speaker_out, 1'b0)
    wreg(CCS_OFS_STATUS, 8'h78);
    `CHK(speaker_out, 1'b1)
    wreg(CCS_OFS_STATUS, 8'h70);
    @(posedge clock);
    irq_request <= 1'b1;
    rchk(CCS_OFS_STATUS, 8'h72);
    @(posedge clock);
    host_irq_disable <= 1'b1;
    rchk(CCS_OFS_STATUS, 8'h70);
    irq_request <= 1'b0;
    host_irq_disable <= 1'b0;
    // Ready and write-protect events in I/O mode with the signal enabled
    @(posedge clock);
    card_ready <= 1'b0;
    waitc(3);
    `CHK(state_change_pin_n, 1'b0)
    rchk(CCS_OFS_STATUS, 8'hf0);
    rchk(CCS_OFS_PINREP, 8'h2c);
    @(posedge clock);
    write_protect_state <= 1'b1;
    rchk(CCS_OFS_PINREP, 8'h3c);
    wreg(CCS_OFS_PINREP, 8'h00);
    rchk(CCS_OFS_PINREP, 8'h3c);
    wreg(CCS_OFS_PINREP, 8'h02);
    rchk(CCS_OFS_PINREP, 8'h1c);
    wreg(CCS_OFS_PINREP, 8'h01);
    rchk(CCS_OFS_PINREP, 8'h0c);
    `CHK(state_change_pin_n, 1'b1)
    @(posedge clock);
    card_ready <= 1'b1;
    wreg(CCS_OFS_STATUS, 8'h30);
    `CHK(state_change_pin_n, 1'b1)
    wreg(CCS_OFS_PINREP, 8'h02);
    wreg(CCS_OFS_PINREP, 8'h11);
    rchk(CCS_OFS_PINREP, 8'h1e);
    // Power state requests hold READY busy until the core confirms
    wreg(CCS_OFS_STATUS, 8'h04);
    `CHK(ready_pin, 1'b0)
    `CHK(power_down, 1'b1)
    power_is_down <= 1'b1;
    waitc(4);
    `CHK(ready_pin, 1'b1)
    wreg(CCS_OFS_STATUS, 8'h00);
    `CHK(ready_pin, 1'b0)
    power_is_down <= 1'b0;
    waitc(4);
    `CHK(ready_pin, 1'b1)
    `CHK(power_down, 1'b0)
    @(posedge clock);
    idle_timeout <= 1'b1;
    @(posedge clock);
    idle_timeout <= 1'b0;
    waitc(3);
    `CHK(power_down, 1'b1)
    @(posedge clock);
    command_received <= 1'b1;
    @(posedge clock);
    command_received <= 1'b0;
    waitc(3);
    `CHK(power_down, 1'b0)
    // Soft reset through the option register
    wreg(CCS_OFS_OPTION, 8'h81);
    `CHK(core_hard_reset, 1'b1)
    `CHK(mode_memory, 1'b1)
    rchk(CCS_OFS_OPTION, 8'h80);
    wreg(CCS_OFS_OPTION, 8'h00);
    waitc(2);
    `CHK(core_hard_reset, 1'b0)
    // Hardware reset in mid-run clears a soft reset bit left set
    wreg(CCS_OFS_OPTION, 8'h80);
    rst <= 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    waitc(3);
    `CHK(core_hard_reset, 1'b0)
    rchk(CCS_OFS_OPTION, 8'h00);
    // Odd attribute addresses are not decoded
    host.wr(CCS_BASE + 11'h001, 8'h41);
    rchk(CCS_OFS_OPTION, 8'h00);
    host.rd(CCS_BASE + 11'h001, d, ok);
    `CHK(ok, 1'b0)
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    end_sim();
  end
endmodule
